// *** inc/pms_pkg.sv ***
// constants for the mode strap, expanded control and interrupt enable register bank
package pms_pkg;
    // ------------------------------------------------------------------
    // register addresses on the serial management port
    // ------------------------------------------------------------------
    localparam logic [4:0]  REG_DRC = 5'h10;   // digital control (pll off)
    localparam logic [4:0]  REG_OVR = 5'h16;   // operation_mode_strap_override
    localparam logic [4:0]  REG_STS = 5'h17;   // operation_mode_strap_status
    localparam logic [4:0]  REG_EXP = 5'h18;   // expanded_control
    localparam logic [4:0]  REG_INT = 5'h1b;   // interrupt_control_status
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int OVR_MII      = 0;
    localparam int OVR_RMII     = 1;
    localparam int OVR_NAND     = 5;
    localparam int OVR_RMII_B2B = 6;
    localparam int OVR_MII_B2B  = 7;
    localparam int OVR_BCAST    = 9;
    localparam int STS_ADDR_LSB = 13;
    localparam int STS_BCAST    = 9;
    localparam int STS_MII_B2B  = 7;
    localparam int STS_RMII_B2B = 6;
    localparam int STS_NAND     = 5;
    localparam int STS_RMII     = 1;
    localparam int STS_MII      = 0;
    localparam int EXP_ENERGY_DETECT_POWER_DOWN_OFF = 11;
    localparam int EXP_LATENCY  = 10;
    localparam int EXP_PRE_KEEP = 6;
    localparam int DRC_PLL_OFF  = 4;
    localparam int INT_EN_LSB   = 8;
    localparam int INT_LINK_DN  = 2;
    // ------------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] OVR_RST   = 16'h0001;
    localparam logic [15:0] OVR_WMASK = 16'h03ff;
    localparam logic [15:0] EXP_RST   = 16'h0800;
    localparam logic [15:0] DRC_RST   = 16'h0000;
    localparam logic [15:0] ZERO16    = 16'h0000;
    localparam logic [7:0]  ZERO8     = 8'h00;
    // ------------------------------------------------------------------
    // management frame and preamble constants
    // ------------------------------------------------------------------
    localparam logic [5:0]  MD_PRE_BITS = 6'h20;  // ones before a start
    localparam logic [3:0]  MD_HDR_BITS = 4'hd;   // st1, op, phy addr, reg addr
    localparam logic [4:0]  MD_DAT_BITS = 5'h10;
    localparam logic [1:0]  MD_OP_RD    = 2'h2;
    localparam logic [1:0]  MD_OP_WR    = 2'h1;
    localparam logic [1:0]  MD_TA_BITS  = 2'h2;
    localparam logic [3:0]  RX_PRE_NIB  = 4'h5;
    localparam logic [3:0]  RX_SFD_HI   = 4'hd;
endpackage : pms_pkg

// *** hw/pms_mdio_slave.sv ***
// serial management frame engine: decodes frames, drives read data
module pms_mdio_slave
    import pms_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    input  wire logic [2:0]  station_addr,
    input  wire logic        bcast_off,
    input  wire logic [15:0] rd_data,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    output logic             rd_stb,
    output logic             wr_stb,
    output logic [4:0]       reg_addr,
    output logic [15:0]      wr_data
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_HDR  = 4'b0010,
        S_TA   = 4'b0100,
        S_DATA = 4'b1000
    } pms_md_state_t;

    pms_md_state_t state_q;
    logic          mdc_q;
    logic          is_rd_q;
    logic [5:0]    ones_q;
    logic [4:0]    cnt_q;
    logic [12:0]   hdr_q;
    logic [15:0]   sh_q;
    logic          rise;
    logic          hit;

    assign rise = mdc & ~mdc_q;
    // address zero is broadcast unless broadcast-disable is in force
    assign hit  = (hdr_q[9:5] == {2'h0, station_addr}) || (hdr_q[9:5] == 5'h00 && !bcast_off);

    // ------------------------------------------------------------------
    // frame sequencer, one step per rising mdc
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        rd_stb <= 1'b0;
        wr_stb <= 1'b0;
        mdc_q  <= mdc;
        if (sys_rst) begin
            state_q   <= S_IDLE;
            ones_q    <= 6'h00;
            cnt_q     <= 5'h00;
            hdr_q     <= 13'h0000;
            sh_q      <= ZERO16;
            is_rd_q   <= 1'b0;
            mdio_out  <= 1'b1;
            mdio_oe_n <= 1'b1;
            reg_addr  <= 5'h00;
            wr_data   <= ZERO16;
        end else if (rise) begin
            case (state_q)
                S_IDLE: begin
                    mdio_oe_n <= 1'b1;
                    if (mdio_in) begin
                        ones_q <= (ones_q == MD_PRE_BITS) ? ones_q : ones_q + 6'h01;
                    end else begin
                        if (ones_q == MD_PRE_BITS) begin
                            state_q <= S_HDR;
                            cnt_q   <= 5'h00;
                        end
                        ones_q <= 6'h00;
                    end
                end
                S_HDR: begin
                    // count runs up to the header length; the decode follows between rises
                    hdr_q <= {hdr_q[11:0], mdio_in};
                    cnt_q <= cnt_q + 5'h01;
                end
                S_TA: begin
                    cnt_q <= cnt_q + 5'h01;
                    // first turnaround bit: drive zero, latch the word, then clear on read
                    if (is_rd_q && cnt_q[1:0] != MD_TA_BITS - 2'h1) begin
                        mdio_out  <= 1'b0;
                        mdio_oe_n <= 1'b0;
                        sh_q      <= rd_data;
                        rd_stb    <= 1'b1;
                    end
                    // second turnaround bit: msb goes out so the master sees it next rise
                    if (is_rd_q && cnt_q[1:0] == MD_TA_BITS - 2'h1) begin
                        mdio_out <= sh_q[15];
                        sh_q     <= {sh_q[14:0], 1'b0};
                    end
                    if (cnt_q[1:0] == MD_TA_BITS - 2'h1) begin
                        state_q <= S_DATA;
                        cnt_q   <= 5'h00;
                    end
                end
                S_DATA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (is_rd_q) begin
                        mdio_out <= sh_q[15];
                        sh_q     <= {sh_q[14:0], 1'b0};
                    end else begin
                        sh_q <= {sh_q[14:0], mdio_in};
                    end
                    if (cnt_q == MD_DAT_BITS) begin
                        state_q   <= S_IDLE;
                        mdio_oe_n <= 1'b1;
                        if (!is_rd_q) begin
                            wr_data <= sh_q;
                            wr_stb  <= 1'b1;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end else if (state_q == S_HDR && cnt_q == {1'b0, MD_HDR_BITS}) begin
            // header complete: check start bit, opcode and address
            cnt_q    <= 5'h00;
            reg_addr <= hdr_q[4:0];
            is_rd_q  <= (hdr_q[11:10] == MD_OP_RD);
            state_q  <= (hdr_q[12] && hit && (hdr_q[11:10] == MD_OP_RD
                        || hdr_q[11:10] == MD_OP_WR)) ? S_TA : S_IDLE;
        end
    end
endmodule : pms_mdio_slave

// *** hw/pms_rx_preamble.sv ***
// receive nibble path: keeps or strips the preamble ahead of the start delimiter
module pms_rx_preamble
    import pms_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       speed_10,
    input  wire logic       keep_pre,
    input  wire logic       rx_dv_in,
    input  wire logic [3:0] rxd_in,
    output logic            rx_dv_out,
    output logic [3:0]      rxd_out
);
    logic       dv_p_q;
    logic [3:0] nib_p_q;
    logic       pass_q;
    logic       pass_now;

    // open the gate on the nibble pair 5,d so the frame starts at the delimiter
    assign pass_now = !speed_10 || keep_pre || pass_q
                      || (nib_p_q == RX_PRE_NIB && rxd_in == RX_SFD_HI);

    // ------------------------------------------------------------------
    // one nibble of delay so the delimiter can be seen before it leaves
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dv_p_q    <= 1'b0;
            nib_p_q   <= 4'h0;
            pass_q    <= 1'b0;
            rx_dv_out <= 1'b0;
            rxd_out   <= 4'h0;
        end else begin
            dv_p_q    <= rx_dv_in;
            nib_p_q   <= rxd_in;
            pass_q    <= rx_dv_in && dv_p_q && pass_now;
            rx_dv_out <= dv_p_q && pass_now;
            rxd_out   <= nib_p_q;
        end
    end
endmodule : pms_rx_preamble

// *** hw/pms_mode_regs.sv ***
// mode strap override, strap status, expanded control and interrupt register bank
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module pms_mode_regs
    import pms_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe_n,
    input  wire logic [2:0] strapped_station_address,
    input  wire logic       strap_bcast_off,
    input  wire logic       strap_mii,
    input  wire logic       strap_rmii,
    input  wire logic       strap_mii_b2b,
    input  wire logic       strap_rmii_b2b,
    input  wire logic       strap_nand_tree,
    input  wire logic [7:0] irq_event,
    input  wire logic       speed_10,
    input  wire logic       rx_dv_in,
    input  wire logic [3:0] rxd_in,
    output logic            rx_dv_out,
    output logic [3:0]      rxd_out,
    output logic            mode_mii_q,
    output logic            mode_rmii_q,
    output logic            mode_mii_b2b_q,
    output logic            mode_rmii_b2b_q,
    output logic            mode_nand_tree_q,
    output logic            energy_detect_power_down_q,
    output logic            pll_off_in_power_down_q,
    output logic            rx_random_latency_q,
    output logic            irq_q
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [15:0] ovr_q;
    logic [15:0] exp_q;
    logic [15:0] drc_q;
    logic [7:0]  int_en_q;
    logic [7:0]  int_sts_q;
    logic [2:0]  st_addr_q;
    logic        st_bcast_q;
    logic        st_mii_q;
    logic        st_rmii_q;
    logic        st_mii_b2b_q;
    logic        st_rmii_b2b_q;
    logic        st_nand_q;
    logic        st_taken_q;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;
    logic [15:0] sts_word;

    // ------------------------------------------------------------------
    // serial management frame engine and receive preamble gate
    // ------------------------------------------------------------------
    pms_mdio_slave u_mdio (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .mdc          (mdc),
        .mdio_in      (mdio_in),
        .station_addr (st_addr_q),
        .bcast_off    (st_bcast_q | ovr_q[OVR_BCAST]),
        .rd_data      (rd_data),
        .mdio_out     (mdio_out),
        .mdio_oe_n    (mdio_oe_n),
        .rd_stb       (rd_stb),
        .wr_stb       (wr_stb),
        .reg_addr     (reg_addr),
        .wr_data      (wr_data)
    );

    pms_rx_preamble u_rxpre (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .speed_10  (speed_10),
        .keep_pre  (exp_q[EXP_PRE_KEEP]),
        .rx_dv_in  (rx_dv_in),
        .rxd_in    (rxd_in),
        .rx_dv_out (rx_dv_out),
        .rxd_out   (rxd_out)
    );

    // write strobe decode, used by every writable register
    function automatic logic wr_hit(input logic stb, input logic [4:0] a, input logic [4:0] r);
        return stb && (a == r);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // strap capture once after reset release, then held
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_taken_q    <= 1'b0;
            st_addr_q     <= 3'h0;
            st_bcast_q    <= 1'b0;
            st_mii_q      <= 1'b0;
            st_rmii_q     <= 1'b0;
            st_mii_b2b_q  <= 1'b0;
            st_rmii_b2b_q <= 1'b0;
            st_nand_q     <= 1'b0;
        end else if (!st_taken_q) begin
            st_taken_q    <= 1'b1;
            st_addr_q     <= strapped_station_address;
            st_bcast_q    <= strap_bcast_off;
            st_mii_q      <= strap_mii;
            st_rmii_q     <= strap_rmii;
            st_mii_b2b_q  <= strap_mii_b2b;
            st_rmii_b2b_q <= strap_rmii_b2b;
            st_nand_q     <= strap_nand_tree;
        end
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovr_q    <= OVR_RST;  // parallel override set at reset
            exp_q    <= EXP_RST;  // power-down disabled, fixed latency
            drc_q    <= DRC_RST;
            int_en_q <= ZERO8;
        end else begin
            if (wr_hit(wr_stb, reg_addr, REG_OVR)) begin
                ovr_q <= wr_data & OVR_WMASK;
            end
            if (wr_hit(wr_stb, reg_addr, REG_EXP)) begin
                exp_q <= wr_data;
            end
            if (wr_hit(wr_stb, reg_addr, REG_DRC)) begin
                drc_q <= wr_data;
            end
            if (wr_hit(wr_stb, reg_addr, REG_INT)) begin
                int_en_q <= wr_data[INT_EN_LSB +: 8];
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt status: events set, a read clears, a set wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_sts_q <= ZERO8;
            irq_q     <= 1'b0;
        end else begin
            int_sts_q <= (wr_hit(rd_stb, reg_addr, REG_INT) ? ZERO8 : int_sts_q)
                         | irq_event;
            irq_q     <= |(int_sts_q & int_en_q);
        end
    end

    // ------------------------------------------------------------------
    // effective operating modes: override first, then strap
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_mii_q                 <= 1'b0;
            mode_rmii_q                <= 1'b0;
            mode_mii_b2b_q             <= 1'b0;
            mode_rmii_b2b_q            <= 1'b0;
            mode_nand_tree_q           <= 1'b0;
            energy_detect_power_down_q <= 1'b0;
            pll_off_in_power_down_q    <= 1'b0;
            rx_random_latency_q        <= 1'b0;
        end else begin
            mode_rmii_q     <= ovr_q[OVR_RMII] | (!ovr_q[OVR_MII] & st_rmii_q);
            mode_mii_q      <= !ovr_q[OVR_RMII] & (ovr_q[OVR_MII] | st_mii_q);
            mode_mii_b2b_q  <= ovr_q[OVR_MII_B2B] | st_mii_b2b_q;
            mode_rmii_b2b_q <= ovr_q[OVR_RMII_B2B] | st_rmii_b2b_q;
            mode_nand_tree_q <= ovr_q[OVR_NAND] | st_nand_q;
            energy_detect_power_down_q <= !exp_q[EXP_ENERGY_DETECT_POWER_DOWN_OFF];
            pll_off_in_power_down_q <= !exp_q[EXP_ENERGY_DETECT_POWER_DOWN_OFF] & drc_q[DRC_PLL_OFF];
            rx_random_latency_q <= !speed_10 & exp_q[EXP_LATENCY];
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        sts_word = ZERO16;
        sts_word[STS_ADDR_LSB +: 3] = st_addr_q;
        sts_word[STS_BCAST]         = st_bcast_q;
        sts_word[STS_MII_B2B]       = st_mii_b2b_q;
        sts_word[STS_RMII_B2B]      = st_rmii_b2b_q;
        sts_word[STS_NAND]          = st_nand_q;
        sts_word[STS_RMII]          = st_rmii_q;
        sts_word[STS_MII]           = st_mii_q;
        case (reg_addr)
            REG_OVR: rd_data = ovr_q;
            REG_STS: rd_data = sts_word;
            REG_EXP: rd_data = exp_q;
            REG_DRC: rd_data = drc_q;
            REG_INT: rd_data = {int_en_q, int_sts_q};
            default: rd_data = ZERO16;
        endcase
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_nand_ovr;
        @(posedge clk) disable iff (sys_rst)
        ovr_q[OVR_NAND] |=> mode_nand_tree_q;
    endproperty
    a_nand_ovr: assert property (p_nand_ovr) else $error("nand override not applied");

    property p_rmii_ovr;
        @(posedge clk) disable iff (sys_rst)
        ovr_q[OVR_RMII] |=> mode_rmii_q && !mode_mii_q;
    endproperty
    a_rmii_ovr: assert property (p_rmii_ovr) else $error("rmii override not applied");

    property p_mii_ovr;
        @(posedge clk) disable iff (sys_rst)
        ovr_q[OVR_MII] && !ovr_q[OVR_RMII] |=> mode_mii_q;
    endproperty
    a_mii_ovr: assert property (p_mii_ovr) else $error("mii override not applied");

    property p_mii_rst;
        @(posedge clk) sys_rst |=> ovr_q == OVR_RST && exp_q == EXP_RST;
    endproperty
    a_mii_rst: assert property (p_mii_rst) else $error("wrong reset value");

    property p_strap_hold;
        @(posedge clk) disable iff (sys_rst)
        st_taken_q && $past(st_taken_q) |-> $stable(st_addr_q) && $stable(st_nand_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

    property p_evt_set;
        @(posedge clk) disable iff (sys_rst)
        irq_event[INT_LINK_DN] |=> int_sts_q[INT_LINK_DN];
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("event lost");

    property p_rd_clr;
        @(posedge clk) disable iff (sys_rst)
        rd_stb && reg_addr == REG_INT && irq_event == ZERO8 ##1 irq_event == ZERO8
            |-> ##1 int_sts_q == ZERO8;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read did not clear");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        |(int_sts_q & int_en_q) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_lkdn_mask;
        @(posedge clk) disable iff (sys_rst)
        (int_sts_q & int_en_q) == ZERO8 |=> !irq_q;
    endproperty
    a_lkdn_mask: assert property (p_lkdn_mask) else $error("masked irq raised");

    property p_energy_detect_power_down;
        @(posedge clk) disable iff (sys_rst)
        !exp_q[EXP_ENERGY_DETECT_POWER_DOWN_OFF] ##1 !exp_q[EXP_ENERGY_DETECT_POWER_DOWN_OFF] |-> energy_detect_power_down_q;
    endproperty
    a_energy_detect_power_down: assert property (p_energy_detect_power_down) else $error("power-down not enabled");

    property p_mii_b2b_ovr;
        @(posedge clk) disable iff (sys_rst)
        ovr_q[OVR_MII_B2B] |=> mode_mii_b2b_q;
    endproperty
    a_mii_b2b_ovr: assert property (p_mii_b2b_ovr) else $error("mii b2b lost");

    property p_rmii_b2b_ovr;
        @(posedge clk) disable iff (sys_rst)
        ovr_q[OVR_RMII_B2B] |=> mode_rmii_b2b_q;
    endproperty
    a_rmii_b2b_ovr: assert property (p_rmii_b2b_ovr) else $error("rmii b2b lost");

    property p_en_rst;
        @(posedge clk)
        sys_rst |=> int_en_q == ZERO8 && int_sts_q == ZERO8;
    endproperty
    a_en_rst: assert property (p_en_rst) else $error("interrupt reset value wrong");

    property p_energy_detect_power_down_off;
        @(posedge clk) disable iff (sys_rst)
        exp_q[EXP_ENERGY_DETECT_POWER_DOWN_OFF] |=> !energy_detect_power_down_q && !pll_off_in_power_down_q;
    endproperty
    a_energy_detect_power_down_off: assert property (p_energy_detect_power_down_off) else $error("power-down while disabled");
endmodule : pms_mode_regs

// *** test/pms_mac_model.sv ***
// mac-side station management master model for the serial management port
module pms_mac_model
    import pms_pkg::*;
(
    input  wire logic clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe_n,
    output logic      mdc,
    output logic      mdio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bit_q = 1'b1;
    logic en_q  = 1'b0;
    // pull-up keeps a released line high
    assign mdio_in = !mdio_oe_n ? mdio_out : (en_q ? bit_q : 1'b1);
    initial mdc = 1'b0;
    // one mdc period, four clk per half; the line is sampled at the rise
    task automatic tick(output logic s);
        repeat (4) @(posedge clk);
        #1 mdc = 1'b1;
        s = mdio_in;
        repeat (4) @(posedge clk);
        #1 mdc = 1'b0;
    endtask : tick
    // one whole frame, always with a fresh preamble
    task automatic xfer(input logic [2:0] pa, input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] sh;
        logic        s;
        sh = {32'hffffffff, 2'b01, op, 2'b00, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--) begin
            en_q = (i > 17) || (op == MD_OP_WR);
            bit_q = sh[i];
            tick(s);
            if (i < 16) rd[i] = s;
        end
        en_q = 1'b0;
        tick(s);
    endtask : xfer
endmodule : pms_mac_model

// *** test/test_phy_mode_strap_and_irq_enable_regs.sv ***
// self-checking bench for the mode strap, expanded control and interrupt register bank
module test_phy_mode_strap_and_irq_enable_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pms_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, mdc, mdio_in, mdio_out, mdio_oe_n, rx_dv_out, irq_q;
    logic [2:0] strapped_station_address = 3'h5;
    logic strap_bcast_off = 1'b1, strap_mii = 1'b0, strap_rmii = 1'b0, strap_mii_b2b = 1'b1;
    logic strap_rmii_b2b = 1'b0, strap_nand_tree = 1'b0, speed_10 = 1'b0, rx_dv_in = 1'b0;
    logic [7:0] irq_event = 8'h00;
    logic [3:0] rxd_in = 4'h0, rxd_out;
    logic mode_mii_q, mode_rmii_q, mode_mii_b2b_q, mode_rmii_b2b_q, mode_nand_tree_q;
    logic energy_detect_power_down_q, pll_off_in_power_down_q, rx_random_latency_q;
    logic [15:0] rv;
    int bad_count = 0, n_tests = 0, cyc = 0;
    pms_mode_regs pms_mode_regs_inst (.clk, .sys_rst, .mdc, .mdio_in, .mdio_out, .mdio_oe_n,
        .strapped_station_address, .strap_bcast_off, .strap_mii, .strap_rmii, .strap_mii_b2b,
        .strap_rmii_b2b, .strap_nand_tree, .irq_event, .speed_10, .rx_dv_in, .rxd_in,
        .rx_dv_out, .rxd_out, .mode_mii_q, .mode_rmii_q, .mode_mii_b2b_q, .mode_rmii_b2b_q,
        .mode_nand_tree_q, .energy_detect_power_down_q, .pll_off_in_power_down_q,
        .rx_random_latency_q, .irq_q);
    pms_mac_model pms_mac_model_inst (.clk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);
    // clock and hang limit
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        pms_mac_model_inst.xfer(3'h5, MD_OP_RD, ra, ZERO16, rv);
        chk("register read", e, rv);
    endtask : rd
    task automatic wr(input logic [2:0] pa, input logic [4:0] ra, input logic [15:0] d);
        pms_mac_model_inst.xfer(pa, MD_OP_WR, ra, d, rv);
        repeat (3) @(posedge clk);
    endtask : wr
    // seven preamble bytes, delimiter, four data nibbles; counts valid output cycles
    task automatic stream(input logic s10, input int e);
        int n;
        logic [3:0] f;
        n = 0;
        f = 4'h0;
        speed_10 = s10;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            #1 if (rx_dv_out && n == 1) f = rxd_out;
            n += int'(rx_dv_out);
            rx_dv_in = (i < 20);
            rxd_in = (i == 15) ? RX_SFD_HI : ((i < 15) ? RX_PRE_NIB : 4'ha);
        end
        chk("rx valid count", 16'(e), 16'(n));
        chk("rx second nibble", {12'h0, ((e == 6) ? RX_SFD_HI : RX_PRE_NIB)},
            {12'h0, f});
    endtask : stream
    task automatic pulse(input logic [7:0] ev);
        @(posedge clk);
        #1 irq_event = ev;
        @(posedge clk);
        #1 irq_event = 8'h00;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic t_reset();
        rd(REG_OVR, OVR_RST);
        rd(REG_STS, 16'ha280);
        rd(REG_EXP, EXP_RST);
        rd(REG_INT, ZERO16);
        rd(5'h1c, ZERO16);
        chk("modes", 16'h0014, {11'h0, mode_mii_q, mode_rmii_q, mode_mii_b2b_q,
            mode_rmii_b2b_q, mode_nand_tree_q});
        chk("power and latency", 16'h0000, {13'h0, energy_detect_power_down_q,
            pll_off_in_power_down_q, rx_random_latency_q});
        {strapped_station_address, strap_bcast_off, strap_mii_b2b, strap_nand_tree} = 6'h0b;
        rd(REG_STS, 16'ha280);
    endtask : t_reset
    task automatic t_override();
        wr(3'h0, REG_OVR, 16'h00e3);
        rd(REG_OVR, OVR_RST);
        wr(3'h5, REG_OVR, 16'h00e3);
        chk("modes", 16'h000f, {11'h0, mode_mii_q, mode_rmii_q, mode_mii_b2b_q,
            mode_rmii_b2b_q, mode_nand_tree_q});
        rd(REG_OVR, 16'h00e3);
        wr(3'h5, REG_STS, 16'hffff);
        rd(REG_STS, 16'ha280);
    endtask : t_override
    task automatic t_expanded();
        stream(1'b1, 6);
        wr(3'h5, REG_EXP, 16'h0440);
        wr(3'h5, REG_DRC, 16'h0010);
        stream(1'b1, 20);
        stream(1'b0, 20);
        chk("power and latency", 16'h0007, {13'h0, energy_detect_power_down_q,
            pll_off_in_power_down_q, rx_random_latency_q});
    endtask : t_expanded
    task automatic t_irq();
        wr(3'h5, REG_INT, 16'h0400);
        pulse(8'h04);
        chk("irq", 16'h0001, {15'h0, irq_q});
        rd(REG_INT, 16'h0404);
        chk("irq", 16'h0000, {15'h0, irq_q});
        pulse(8'h01);
        chk("irq", 16'h0000, {15'h0, irq_q});
        rd(REG_INT, 16'h0401);
        wr(3'h5, REG_INT, ZERO16);
        pulse(8'h04);
        chk("irq", 16'h0000, {15'h0, irq_q});
        rd(REG_INT, 16'h0004);
    endtask : t_irq
    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_override();
        t_expanded();
        t_irq();
        complete_run();
    end
endmodule : test_phy_mode_strap_and_irq_enable_regs
